/* File: core/cmc_mode_ctrl.sv */
`timescale 1ns/1ps
`include "cmc_params.svh"

// Summary of operation
// RL1: requests come from ctrl bits 10:8; mode in force shows at 7:5.
// RL2: on-line modes hold mode and status until the bus idles for 11 recessive bits.
// RL3: initialization: no transmit or receive, counters cleared, flags kept.
// RL4: configuration registers are writable only in initialization mode.
// RL5: initialization entry waits while a transmission is in progress.
// RL6: disable: no traffic, wake flag on activity, flags and counters kept.
// RL7: request 001 waits for bus idle, then disable shows 001.
// RL8: disable releases both bus pins to port use.
// RL9: wake filter bit 14 of second config filters receive while asleep.
// RL10: disable during the post-entry idle wait aborts the pending transmit.
// RL11: request 000 gives normal mode with both pins used for the bus.
// RL12: listen-only is passive: transmit pin released, no flags, no counting.
// RL13: request 111 ignores errors and keeps partial frames on error.
// RL14: loopback ties internal transmit to receive and releases both pins.
// RL15: init, listen-only and loopback use distinct unused codes, echoed.
// RL16: idle detector counts recessive bits, restarting on any dominant bit.
module cmc_mode_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic bus_receive_pin,
    output logic bus_transmit_pin,
    output logic bus_transmit_oe,
    output logic bus_receive_claim,
    input wire cmc_pkg::cmc_eng_in_t eng_in,
    output cmc_pkg::cmc_eng_out_t eng_out
);
    cmc_pkg::cmc_state_t st, next_st;
    logic idle;
    logic wake;
    logic line;
    logic acc_done;
    logic wr;
    logic rd;
    logic txc_mode;

    // decode used by both read and write paths
    function automatic logic cmc_mapped(input logic [7:0] a);
        cmc_mapped = a == `CMC_OFS_CTRL || a == `CMC_OFS_CFG1 ||
            a == `CMC_OFS_CFG2 || a == `CMC_OFS_TXCTL ||
            a == `CMC_OFS_ISTAT || a == `CMC_OFS_IMASK ||
            a == `CMC_OFS_ERRCNT;
    endfunction : cmc_mapped

    // registers whose writes are locked outside initialization
    function automatic logic cmc_locked(input logic [7:0] a);
        cmc_locked = a == `CMC_OFS_CFG1 || a == `CMC_OFS_CFG2 ||
            a == `CMC_OFS_IMASK;
    endfunction : cmc_locked

    // the idle detector watches what the engine would hear
    assign line = (st.mode == cmc_pkg::CMC_LOOPBACK) ? eng_in.tx_bit
        : bus_receive_pin; // see RL14
    assign txc_mode = st.mode == cmc_pkg::CMC_NORMAL ||
        st.mode == cmc_pkg::CMC_LOOPBACK ||
        st.mode == cmc_pkg::CMC_LISTEN_ALL;

    cmc_idle_det u_idle (
        .pclk(pclk),
        .presetn(presetn),
        .bit_div(st.cfg1),
        .restart(st.idle_restart),
        .line(line),
        .idle(idle)
    );

    cmc_wake_filt u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .asleep(st.mode == cmc_pkg::CMC_DISABLE),
        .filt_en(st.wake_filter_enable),
        .line(bus_receive_pin),
        .wake(wake)
    );

    assign acc_done = psel && penable && st.pready;
    assign wr = acc_done && pwrite && !st.pslverr;
    assign rd = acc_done && !pwrite && !st.pslverr;

    // all block state advances here
    always_comb
    begin
        logic [2:0] ev;
        logic accept;
        logic mode_chg;
        ev = 3'h0;
        accept = 1'b0;
        mode_chg = 1'b0;
        next_st = st;
        next_st.idle_restart = 1'b0;
        next_st.eng.tx_go = 1'b0;

        // apb: answer one cycle into the access phase
        next_st.pready = 1'b0;
        if (psel && !penable)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = !cmc_mapped(paddr);
            case (paddr)
                `CMC_OFS_CTRL: next_st.prdata = {21'h0, st.req,
                    st.mode, 5'h00}; // see RL1
                `CMC_OFS_CFG1: next_st.prdata = {24'h0, st.cfg1};
                `CMC_OFS_CFG2: next_st.prdata = {17'h0,
                    st.wake_filter_enable, 14'h0};
                `CMC_OFS_TXCTL: next_st.prdata = {31'h0, st.tx_request_bit};
                `CMC_OFS_ISTAT: next_st.prdata = {29'h0, st.istat};
                `CMC_OFS_IMASK: next_st.prdata = {29'h0, st.imask};
                `CMC_OFS_ERRCNT: next_st.prdata = {16'h0, st.rec, st.tec};
                default: next_st.prdata = 32'h0000_0000;
            endcase
        end

        // software writes; a locked write is dropped without error
        if (wr)
        begin
            case (paddr)
                `CMC_OFS_CTRL:
                    next_st.req = cmc_pkg::cmc_mode_t'(
                        pwdata[`CMC_REQ_HI:`CMC_REQ_LO]); // see RL1
                `CMC_OFS_TXCTL:
                    if (pwdata[`CMC_TX_REQUEST_BIT_BIT])
                        next_st.tx_request_bit = 1'b1;
                default: ;
            endcase
            if (st.mode == cmc_pkg::CMC_INIT && cmc_locked(paddr)) // see RL4
            begin
                case (paddr)
                    `CMC_OFS_CFG1: next_st.cfg1 = pwdata[7:0];
                    `CMC_OFS_CFG2: next_st.wake_filter_enable =
                        pwdata[`CMC_WAKFILT_BIT];
                    default: next_st.imask = pwdata[2:0];
                endcase
            end
        end

        // disable requested while a transmit still waits: abort it
        if (next_st.req == cmc_pkg::CMC_DISABLE && st.tx_request_bit &&
            next_st.tx_request_bit && !idle)
        begin
            next_st.tx_request_bit = 1'b0; // see RL10
            ev[`CMC_IRQ_ABORT] = 1'b1;
        end
        else if (st.tx_request_bit && txc_mode && idle &&
            !st.idle_restart && !eng_in.tx_busy)
        begin
            next_st.eng.tx_go = 1'b1; // see RL10
            next_st.tx_request_bit = 1'b0;
        end

        // off-line modes change at once; on-line ones wait for idle
        if (st.req != st.mode)
        begin
            accept = (st.mode == cmc_pkg::CMC_INIT ||
                st.mode == cmc_pkg::CMC_DISABLE || idle) &&
                !st.idle_restart; // see RL2 RL7
            if (st.req == cmc_pkg::CMC_INIT && eng_in.tx_busy)
                accept = 1'b0; // see RL5
            case (st.req)
                cmc_pkg::CMC_NORMAL, cmc_pkg::CMC_DISABLE,
                cmc_pkg::CMC_LOOPBACK, cmc_pkg::CMC_LISTEN,
                cmc_pkg::CMC_INIT, cmc_pkg::CMC_LISTEN_ALL: ;
                default: accept = 1'b0; // unassigned codes never take effect
            endcase
        end
        if (accept)
        begin
            next_st.mode = st.req; // see RL15
            next_st.idle_restart = 1'b1; // new mode waits for fresh idle
            mode_chg = 1'b1;
        end
        ev[`CMC_IRQ_MODE] = mode_chg;
        ev[`CMC_IRQ_WAKE] = wake; // see RL6

        // error counters per mode
        case (st.mode)
            cmc_pkg::CMC_INIT:
            begin
                next_st.tec = 8'h00; // see RL3
                next_st.rec = 8'h00;
            end
            cmc_pkg::CMC_NORMAL, cmc_pkg::CMC_LOOPBACK:
            begin
                if (eng_in.err_tx && st.tec != 8'hFF)
                    next_st.tec = st.tec + 8'h01;
                if (eng_in.err_rx && st.rec != 8'hFF)
                    next_st.rec = st.rec + 8'h01;
            end
            default: ; // disable keeps, listen modes do not count
        endcase

        // pins and engine qualifiers for the mode in force
        next_st.eng.rx_en = 1'b0;
        next_st.eng.tx_en = 1'b0;
        next_st.eng.ack_en = 1'b0;
        next_st.eng.keep_on_error = 1'b0;
        next_st.eng.rx_bit = 1'b1;
        next_st.bus_transmit_oe = 1'b0;
        next_st.bus_receive_claim = 1'b0;
        next_st.bus_transmit_pin = 1'b1;
        case (next_st.mode)
            cmc_pkg::CMC_NORMAL:
            begin
                next_st.eng.rx_en = 1'b1; // see RL11
                next_st.eng.tx_en = 1'b1;
                next_st.eng.ack_en = 1'b1;
                next_st.eng.rx_bit = bus_receive_pin;
                next_st.bus_transmit_oe = 1'b1;
                next_st.bus_receive_claim = 1'b1;
                next_st.bus_transmit_pin = eng_in.tx_bit;
            end
            cmc_pkg::CMC_LISTEN:
            begin
                next_st.eng.rx_en = 1'b1; // see RL12
                next_st.eng.rx_bit = bus_receive_pin;
                next_st.bus_receive_claim = 1'b1;
            end
            cmc_pkg::CMC_LISTEN_ALL:
            begin
                next_st.eng.rx_en = 1'b1; // see RL13
                next_st.eng.tx_en = 1'b1;
                next_st.eng.ack_en = 1'b1;
                next_st.eng.keep_on_error = 1'b1;
                next_st.eng.rx_bit = bus_receive_pin;
                next_st.bus_transmit_oe = 1'b1;
                next_st.bus_receive_claim = 1'b1;
                next_st.bus_transmit_pin = eng_in.tx_bit;
            end
            cmc_pkg::CMC_LOOPBACK:
            begin
                next_st.eng.rx_en = 1'b1; // see RL14
                next_st.eng.tx_en = 1'b1;
                next_st.eng.ack_en = 1'b1;
                next_st.eng.rx_bit = eng_in.tx_bit;
            end
            default: ; // init and disable: silent, pins released, see RL3 RL8
        endcase

        // sticky status, read clears, a new event wins over the clear
        if (rd && paddr == `CMC_OFS_ISTAT)
            next_st.istat = ev;
        else
            next_st.istat = st.istat | ev;
        next_st.irq = |(next_st.istat & next_st.imask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.req <= cmc_pkg::CMC_INIT;
            st.mode <= cmc_pkg::CMC_INIT;
            st.cfg1 <= `CMC_CFG1_RST;
            st.imask <= `CMC_IMASK_RST;
            st.bus_transmit_pin <= 1'b1;
            st.eng.rx_bit <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
    assign bus_transmit_pin = st.bus_transmit_pin;
    assign bus_transmit_oe = st.bus_transmit_oe;
    assign bus_receive_claim = st.bus_receive_claim;
    assign eng_out = st.eng;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // checks sample registered state, so each sees the previous edge's work

    a_mode_hold_busy: assert property ( // see RL2
        !idle && st.mode != cmc_pkg::CMC_INIT &&
        st.mode != cmc_pkg::CMC_DISABLE |=> $stable(st.mode))
        else $error("mode changed on a busy bus");
    a_init_no_tx: assert property ( // see RL5
        st.req == cmc_pkg::CMC_INIT && eng_in.tx_busy &&
        st.mode != cmc_pkg::CMC_INIT |=> st.mode != cmc_pkg::CMC_INIT)
        else $error("init entered during transmission");
    a_init_clears: assert property ( // see RL3
        st.mode == cmc_pkg::CMC_INIT ##1 st.mode == cmc_pkg::CMC_INIT
        |-> st.tec == 8'h00 && st.rec == 8'h00 && !eng_out.tx_en)
        else $error("init left counters or transmit active");
    a_cfg_lock: assert property ( // see RL4
        wr && paddr == `CMC_OFS_CFG1 && st.mode != cmc_pkg::CMC_INIT
        |=> $stable(st.cfg1))
        else $error("locked register written on-line");
    a_disable_pins: assert property ( // see RL8
        st.mode == cmc_pkg::CMC_DISABLE |=> !bus_transmit_oe &&
        !bus_receive_claim || st.mode != cmc_pkg::CMC_DISABLE)
        else $error("pins held in disable");
    a_disable_keeps: assert property ( // see RL6
        st.mode == cmc_pkg::CMC_DISABLE [*2] |-> $stable(st.tec) &&
        $stable(st.rec))
        else $error("counters moved in disable");
    a_abort_flag: assert property ( // see RL10
        wr && paddr == `CMC_OFS_CTRL && pwdata[`CMC_REQ_HI:`CMC_REQ_LO]
        == 3'h1 && st.tx_request_bit && !idle
        |=> !st.tx_request_bit && st.istat[`CMC_IRQ_ABORT])
        else $error("pending transmit not aborted");
    a_listen_passive: assert property ( // see RL12
        st.mode == cmc_pkg::CMC_LISTEN |-> (!bus_transmit_oe &&
        !eng_out.ack_en) ##1 $stable(st.tec))
        else $error("listen-only drove the bus");
    a_loop_route: assert property ( // see RL14
        st.mode == cmc_pkg::CMC_LOOPBACK && next_st.mode ==
        cmc_pkg::CMC_LOOPBACK |=> eng_out.rx_bit == $past(eng_in.tx_bit)
        && !bus_transmit_oe)
        else $error("loopback not routed");
    a_normal_drive: assert property ( // see RL11
        st.mode == cmc_pkg::CMC_NORMAL && next_st.mode == cmc_pkg::CMC_NORMAL
        |=> bus_transmit_oe && bus_transmit_pin == $past(eng_in.tx_bit))
        else $error("normal mode not driving");
    a_listen_all: assert property ( // see RL13
        st.mode == cmc_pkg::CMC_LISTEN_ALL && next_st.mode ==
        cmc_pkg::CMC_LISTEN_ALL |=> eng_out.keep_on_error)
        else $error("listen-all not keeping frames");
    a_irq_level: assert property (
        |(st.istat & st.imask) |-> irq)
        else $error("unmasked status without interrupt");
    a_wake_asleep: assert property ( // see RL6
        wake |-> $past(st.mode) == cmc_pkg::CMC_DISABLE)
        else $error("wake seen outside disable");

    c_to_normal: cover property (st.mode == cmc_pkg::CMC_INIT ##1
        st.mode == cmc_pkg::CMC_NORMAL);
    c_to_disable: cover property (st.mode == cmc_pkg::CMC_DISABLE);
    c_abort: cover property (st.istat[`CMC_IRQ_ABORT]);
    c_wake: cover property (st.istat[`CMC_IRQ_WAKE]);
    c_tx_start: cover property (eng_out.tx_go);
endmodule : cmc_mode_ctrl

/* File: shared/cmc_params.svh */
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH

// register byte offsets
`define CMC_OFS_CTRL 8'h00
`define CMC_OFS_CFG1 8'h04
`define CMC_OFS_CFG2 8'h08
`define CMC_OFS_TXCTL 8'h0C
`define CMC_OFS_ISTAT 8'h10
`define CMC_OFS_IMASK 8'h14
`define CMC_OFS_ERRCNT 8'h18

// field positions
`define CMC_REQ_HI 10
`define CMC_REQ_LO 8
`define CMC_STAT_HI 7
`define CMC_STAT_LO 5
`define CMC_WAKFILT_BIT 14
`define CMC_TX_REQUEST_BIT_BIT 0
`define CMC_IRQ_WAKE 0
`define CMC_IRQ_ABORT 1
`define CMC_IRQ_MODE 2

// reset values
`define CMC_CFG1_RST 8'h09
`define CMC_IMASK_RST 3'h0

// timing
`define CMC_IDLE_BITS 4'hB
`define CMC_CLK_PERIOD_NS 5
`define CMC_WAKE_FILT_NS 100
`define CMC_WAKE_FILT_CYC \
    ((`CMC_WAKE_FILT_NS + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS)

`endif

/* File: shared/cmc_pkg.sv */
package cmc_pkg;

    // mode codes, shared by request and status fields
    typedef enum logic [2:0] {
        CMC_NORMAL = 3'h0,
        CMC_DISABLE = 3'h1,
        CMC_LOOPBACK = 3'h2,
        CMC_LISTEN = 3'h3,
        CMC_INIT = 3'h4,
        CMC_LISTEN_ALL = 3'h7
    } cmc_mode_t;

    // from the protocol engine
    typedef struct packed {
        logic tx_bit;
        logic tx_busy;
        logic err_tx;
        logic err_rx;
    } cmc_eng_in_t;

    // to the protocol engine
    typedef struct packed {
        logic rx_bit;
        logic rx_en;
        logic tx_en;
        logic ack_en;
        logic keep_on_error;
        logic tx_go;
    } cmc_eng_out_t;

    typedef struct packed {
        logic [7:0] div;
        logic [3:0] bits;
        logic idle;
    } cmc_idle_st_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic armed;
        logic wake;
    } cmc_wake_st_t;

    typedef struct packed {
        cmc_mode_t req;
        cmc_mode_t mode;
        logic [7:0] cfg1;
        logic wake_filter_enable;
        logic [2:0] imask;
        logic [2:0] istat;
        logic tx_request_bit;
        logic [7:0] tec;
        logic [7:0] rec;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic bus_transmit_pin;
        logic bus_transmit_oe;
        logic bus_receive_claim;
        logic idle_restart;
        cmc_eng_out_t eng;
    } cmc_state_t;

endpackage : cmc_pkg

/* File: core/cmc_idle_det.sv */
`timescale 1ns/1ps
`include "cmc_params.svh"

module cmc_idle_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] bit_div,
    input wire logic restart,
    input wire logic line,
    output logic idle
);
    cmc_pkg::cmc_idle_st_t st, next_st;

    // sample once per bit time, count recessive bits, dominant restarts
    always_comb
    begin
        next_st = st;
        if (restart)
        begin
            next_st.div = 8'h00;
            next_st.bits = 4'h0;
            next_st.idle = 1'b0;
        end
        else if (st.div >= bit_div)
        begin
            next_st.div = 8'h00;
            if (!line)
            begin
                next_st.bits = 4'h0; // see RL16
                next_st.idle = 1'b0;
            end
            else if (st.bits < `CMC_IDLE_BITS)
                next_st.bits = st.bits + 4'h1;
        end
        else
            next_st.div = st.div + 8'h01;
        if (!restart && line && st.bits >= `CMC_IDLE_BITS)
            next_st.idle = 1'b1; // see RL16
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign idle = st.idle;
endmodule : cmc_idle_det

/* File: core/cmc_wake_filt.sv */
`timescale 1ns/1ps
`include "cmc_params.svh"

module cmc_wake_filt (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic asleep,
    input wire logic filt_en,
    input wire logic line,
    output logic wake
);
    localparam logic [4:0] FILT_CYC = 5'(`CMC_WAKE_FILT_CYC);
    cmc_pkg::cmc_wake_st_t st, next_st;

    // a dominant pulse shorter than the filter time is treated as noise
    always_comb
    begin
        next_st = st;
        next_st.wake = 1'b0;
        if (!asleep || line)
        begin
            next_st.cnt = 5'h00;
            next_st.armed = asleep;
        end
        else if (st.armed)
        begin
            if (!filt_en || st.cnt + 5'h01 >= FILT_CYC) // see RL9
            begin
                next_st.wake = 1'b1;
                next_st.armed = 1'b0; // one pulse per dominant stretch
            end
            else
                next_st.cnt = st.cnt + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign wake = st.wake;
endmodule : cmc_wake_filt

/* File: dv/cmc_bus_node.sv */
`timescale 1ns/1ps

// another node on the shared bus; drive low is dominant
module cmc_bus_node (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] bit_div,
    input wire logic send,
    input wire logic hold,
    output logic drive
);
    logic [7:0] cnt;
    logic [1:0] bidx;

    // bit timer; three dominant bits then one recessive keeps the bus busy
    // while no low stretch is long enough to pass a wake filter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 8'h0;
            bidx <= 2'h0;
        end
        else if (cnt == bit_div)
        begin
            cnt <= 8'h0;
            bidx <= bidx + 2'h1;
        end
        else
            cnt <= cnt + 8'h1;
    end

    // recessive when quiet; hold gives one long dominant stretch
    assign drive = !(hold || (send && bidx != 2'h3));
endmodule : cmc_bus_node

/* File: dv/tb_can_operating_mode_control.sv */
`timescale 1ns/1ps
`include "cmc_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module tb_can_operating_mode_control;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic err;
    } cmc_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic re, bus_receive_pin, bus_transmit_pin, bus_transmit_oe;
    logic bus_receive_claim, send, hold, node_drive, go_seen;
    cmc_pkg::cmc_eng_in_t eng_in;
    cmc_pkg::cmc_eng_out_t eng_out;
    int failures, compares;
    cmc_row_t rows[10];
    cmc_pkg::cmc_mode_t mc[3];
    logic [1:0] pins[3];

    cmc_mode_ctrl DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .bus_receive_pin(bus_receive_pin),
        .bus_transmit_pin(bus_transmit_pin),
        .bus_transmit_oe(bus_transmit_oe),
        .bus_receive_claim(bus_receive_claim),
        .eng_in(eng_in), .eng_out(eng_out)
    );

    cmc_bus_node node (
        .pclk(pclk), .presetn(presetn), .bit_div(8'h03), .send(send),
        .hold(hold), .drive(node_drive)
    );

    // wired-and bus; a released transmit pin leaves it recessive
    assign bus_receive_pin = node_drive &
        (bus_transmit_oe ? bus_transmit_pin : 1'h1);

    initial
    begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end

    // remembers any transmit start handed to the engine
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            go_seen <= 1'h0;
        else if (eng_out.tx_go)
            go_seen <= 1'h1;

    task close_out;
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        rv = prdata;
        re = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50)
        begin
            `CHK("pready", 1'h1, pready)
            close_out();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        apb(1'h0, a, 32'h0);
        `CHK(n, e, rv)
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // polls the status field; a bounded wait, never open-ended
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        do
        begin
            apb(1'h0, `CMC_OFS_CTRL, 32'h0);
            n++;
        end
        while (rv[7:5] !== m && n < 100);
        if (rv[7:5] !== m)
        begin
            `CHK("mode", m, rv[7:5])
            close_out();
        end
    endtask : wait_mode

    initial
    begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        eng_in = '{tx_bit: 1'h1, default: 1'h0};
        send = 1'h0;
        hold = 1'h0;
        // reset values first, then config writes, a refused code, a hole
        rows = '{'{1'h0, `CMC_OFS_CTRL, 32'h0, 32'h480, 1'h0},
                 '{1'h0, `CMC_OFS_CFG1, 32'h0, 32'h9, 1'h0},
                 '{1'h0, `CMC_OFS_IMASK, 32'h0, 32'h0, 1'h0},
                 '{1'h0, `CMC_OFS_ERRCNT, 32'h0, 32'h0, 1'h0},
                 '{1'h0, `CMC_OFS_ISTAT, 32'h0, 32'h0, 1'h0},
                 '{1'h1, `CMC_OFS_CFG1, 32'h3, 32'h3, 1'h0},
                 '{1'h1, `CMC_OFS_CFG2, 32'h4000, 32'h4000, 1'h0},
                 '{1'h1, `CMC_OFS_IMASK, 32'h7, 32'h7, 1'h0},
                 '{1'h1, `CMC_OFS_CTRL, 32'h500, 32'h580, 1'h0},
                 '{1'h1, 8'h1C, 32'hFF, 32'h0, 1'h1}};
        mc = '{cmc_pkg::CMC_LISTEN, cmc_pkg::CMC_LOOPBACK,
               cmc_pkg::CMC_LISTEN_ALL};
        pins = '{2'h1, 2'h0, 2'h3};
        cyc(3);
        `CHK("oe_rst", 1'h0, bus_transmit_oe)
        `CHK("tx_rst", 1'h1, bus_transmit_pin)
        presetn <= 1'h1;
        foreach (rows[i])
        begin
            if (rows[i].w)
                apb(1'h1, rows[i].a, rows[i].d);
            if (rows[i].w)
                `CHK("wr_err", rows[i].err, re)
            rd(rows[i].a, rows[i].e, "row");
            `CHK("rd_err", rows[i].err, re)
        end
        // normal mode with a busy bus, so the idle wait never ends
        send <= 1'h1;
        apb(1'h1, `CMC_OFS_CTRL, 32'h0);
        cyc(3);
        `CHK("oe_norm", 1'h1, bus_transmit_oe)
        `CHK("claim_norm", 1'h1, bus_receive_claim)
        `CHK("txen_norm", 1'h1, eng_out.tx_en)
        `CHK("irq_mode", 1'h1, irq)
        rd(`CMC_OFS_ISTAT, 32'h4, "istat_norm");
        cyc(1);
        `CHK("irq_clr", 1'h0, irq)
        repeat (2)
        begin
            eng_in.err_rx <= 1'h1;
            cyc(1);
            eng_in.err_rx <= 1'h0;
            cyc(1);
        end
        rd(`CMC_OFS_ERRCNT, 32'h200, "errcnt");
        apb(1'h1, `CMC_OFS_CFG1, 32'h20);
        rd(`CMC_OFS_CFG1, 32'h3, "cfg1_lock");
        apb(1'h1, `CMC_OFS_TXCTL, 32'h1);
        rd(`CMC_OFS_TXCTL, 32'h1, "tx_wait");
        apb(1'h1, `CMC_OFS_CTRL, 32'h100);
        rd(`CMC_OFS_ISTAT, 32'h2, "abort");
        rd(`CMC_OFS_TXCTL, 32'h0, "tx_clr");
        rd(`CMC_OFS_CTRL, 32'h100, "hold_busy");
        // idle is 44 cycles at this divider; still normal before that
        send <= 1'h0;
        cyc(28);
        rd(`CMC_OFS_CTRL, 32'h100, "hold_idle");
        wait_mode(cmc_pkg::CMC_DISABLE);
        cyc(2);
        `CHK("oe_dis", 1'h0, bus_transmit_oe)
        `CHK("claim_dis", 1'h0, bus_receive_claim)
        rd(`CMC_OFS_ERRCNT, 32'h200, "err_keep");
        rd(`CMC_OFS_ISTAT, 32'h4, "istat_dis");
        // short lows are filtered, a long one wakes
        send <= 1'h1;
        cyc(40);
        send <= 1'h0;
        rd(`CMC_OFS_ISTAT, 32'h0, "wake_filt");
        hold <= 1'h1;
        cyc(25);
        hold <= 1'h0;
        cyc(2);
        `CHK("irq_wake", 1'h1, irq)
        rd(`CMC_OFS_ISTAT, 32'h1, "wake");
        apb(1'h1, `CMC_OFS_CTRL, 32'h400);
        wait_mode(cmc_pkg::CMC_INIT);
        rd(`CMC_OFS_ERRCNT, 32'h0, "err_clr");
        foreach (mc[i])
        begin
            apb(1'h1, `CMC_OFS_CTRL, {21'h0, mc[i], 8'h0});
            wait_mode(mc[i]);
            cyc(2);
            `CHK("oe_mode", pins[i][1], bus_transmit_oe)
            `CHK("claim", pins[i][0], bus_receive_claim)
            if (mc[i] == cmc_pkg::CMC_LOOPBACK)
            begin
                eng_in.tx_bit <= 1'h0;
                cyc(2);
                `CHK("loop", 1'h0, eng_out.rx_bit)
                eng_in.tx_bit <= 1'h1;
            end
            // one error pulse; only loopback counts it
            eng_in.err_tx <= 1'h1;
            eng_in.err_rx <= 1'h1;
            cyc(1);
            eng_in.err_tx <= 1'h0;
            eng_in.err_rx <= 1'h0;
            rd(`CMC_OFS_ERRCNT, (mc[i] == cmc_pkg::CMC_LOOPBACK) ?
               32'h101 : 32'h0, "err_mode");
            if (mc[i] == cmc_pkg::CMC_LISTEN_ALL)
            begin
                `CHK("keep_err", 1'h1, eng_out.keep_on_error)
                // a request right after entry waits out the fresh idle
                apb(1'h1, `CMC_OFS_TXCTL, 32'h1);
                rd(`CMC_OFS_TXCTL, 32'h1, "tx_hold");
                `CHK("go_early", 1'h0, go_seen)
                cyc(50);
                rd(`CMC_OFS_TXCTL, 32'h0, "tx_sent");
                `CHK("tx_go", 1'h1, go_seen)
            end
            // init entry must wait out a transmission in progress
            eng_in.tx_busy <= 1'h1;
            apb(1'h1, `CMC_OFS_CTRL, 32'h400);
            cyc(80);
            rd(`CMC_OFS_CTRL, {21'h0, 3'h4, mc[i], 5'h0}, "busy");
            eng_in.tx_busy <= 1'h0;
            wait_mode(cmc_pkg::CMC_INIT);
        end
        close_out();
    end
endmodule : tb_can_operating_mode_control
